/* arc_ctrl.sv */
/*
 * Register bank for keyed target address change, clock calibration
 * readout, self-clearing software reset and operating mode.
 * Assumes the serial front end hands over decoded 16-bit register
 * accesses one cycle wide, and uses the ack output for the data phase.
 */
`include "arc_defines.svh"

// Notes on behaviour
// - Unlock value 04AD always allows a target address change.
// - Unlock value 44AD allows change only while interrupt pin high.
// - Unlock value 84AD allows change only while aux pin high.
// - Unlock value C4AD needs both interrupt and aux pins high.
// - Calibration enable counts fast cycles over two slow periods.
// - Writing one to the soft reset bit resets the device in the following cycle.
// - Soft reset bit clears itself after the reset takes effect.
// - Soft reset write gets no acknowledge; host expects that.
// - Mode field: zero standby, one program, two normal.
module arc_ctrl (
    input  wire logic                  CLK,
    input  wire logic                  RSTN,
    input  wire arc_pkg::arc_req_type  REQ,
    input  wire logic                  INT_PIN,
    input  wire logic                  AUX_OUTPUT_PIN,
    input  wire logic                  SLOW_CLK,
    output logic [15:0]                RDATA,
    output logic                       ACK,
    output logic [6:0]                 TARGET_ADDR,
    output arc_pkg::arc_mode_type      MODE,
    output logic                       CAL_ENABLE,
    output logic                       SOFT_RESET_N
);
    logic [6:0]            addr_r;
    logic [15:0]           key_r;
    arc_pkg::arc_mode_type mode_r;
    logic                  cal_en_r;
    logic                  srst_r;
    logic                  srst_n_r;
    logic [15:0]           rdata_r;
    logic                  ack_r;
    logic [15:0]           rdata_nxt;
    logic [11:0]           cal_count;
    logic                  cal_done;

    // Internal reset joins the pin and the soft reset pulse
    wire rst_all_n = RSTN & ~srst_r;

    // Register decode
    wire hit_addr   = REQ.addr == `ARC_OFS_ADDR;
    wire hit_cal    = REQ.addr == `ARC_OFS_CAL;
    wire hit_key    = REQ.addr == `ARC_OFS_KEY;
    wire hit_srst   = REQ.addr == `ARC_OFS_SRST;
    wire hit_mode   = REQ.addr == `ARC_OFS_MODE;
    wire hit_calctl = REQ.addr == `ARC_OFS_CALCTL;

    wire unlock_ok =
        (key_r == `ARC_KEY_ALWAYS) ||
        (key_r == `ARC_KEY_INT  && INT_PIN) ||
        (key_r == `ARC_KEY_AUX  && AUX_OUTPUT_PIN) ||
        (key_r == `ARC_KEY_BOTH && INT_PIN && AUX_OUTPUT_PIN);

    // write byte must carry key; others ignored
    wire addr_we = REQ.wr && hit_addr && unlock_ok &&
                   REQ.wdata[15:8] == `ARC_WRITE_KEY;

    wire srst_we = REQ.wr && hit_srst && REQ.wdata[0];

    // only listed mode codes are stored; code 3 is dropped
    wire mode_we = REQ.wr && hit_mode && REQ.wdata[1:0] != 2'h3;

    arc_cal_counter u_cal (
        .clk      (CLK),
        .rstn     (rst_all_n),
        .enable   (cal_en_r),
        .slow_clk (SLOW_CLK),
        .count    (cal_count),
        .done     (cal_done)
    );

    // Read multiplexer; key byte of the address register reads zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (hit_addr)
            rdata_nxt = {8'h00, addr_r, 1'b0};
        else if (hit_cal)
            rdata_nxt = {4'h0, cal_count};
        else if (hit_key)
            rdata_nxt = key_r;
        else if (hit_srst)
            rdata_nxt = {15'h0000, srst_r};
        else if (hit_mode)
            rdata_nxt = {14'h0000, mode_r};
        else if (hit_calctl)
            rdata_nxt = {10'h000, cal_en_r, 5'h00};
    end

    // soft reset bit lives one cycle then clears itself
    // The pin copy is its own flop so the output needs no inverter
    always_ff @(posedge CLK) begin
        if (!RSTN || srst_r) begin
            srst_r   <= 1'b0;
            srst_n_r <= 1'b1;
        end else begin
            srst_r   <= srst_we;
            srst_n_r <= ~srst_we;
        end
    end

    // Configuration registers, cleared by pin or soft reset
    always_ff @(posedge CLK) begin
        if (!rst_all_n) begin
            addr_r   <= `ARC_ADDR_RST;
            key_r    <= `ARC_KEY_RST;
            mode_r   <= arc_pkg::ARC_MODE_STANDBY;
            cal_en_r <= 1'b0;
        end else begin
            if (addr_we)
                addr_r <= REQ.wdata[7:1];
            if (REQ.wr && hit_key)
                key_r <= REQ.wdata;
            if (mode_we)
                mode_r <= arc_arc_mode(REQ.wdata[1:0]);
            if (REQ.wr && hit_calctl)
                cal_en_r <= REQ.wdata[`ARC_CAL_EN_BIT];
        end
    end

    // acknowledge every access but the soft reset write and any access in the reset cycle after it
    always_ff @(posedge CLK) begin
        if (!rst_all_n) begin
            ack_r   <= 1'b0;
            rdata_r <= 16'h0000;
        end else begin
            ack_r   <= (REQ.wr || REQ.rd) && !srst_we;
            rdata_r <= REQ.rd ? rdata_nxt : rdata_r;
        end
    end

    function automatic arc_pkg::arc_mode_type arc_arc_mode(
        input logic [1:0] v);
        arc_arc_mode = arc_pkg::arc_mode_type'(v);
    endfunction

    assign RDATA        = rdata_r;
    assign ACK          = ack_r;
    assign TARGET_ADDR  = addr_r;
    assign MODE         = mode_r;
    assign CAL_ENABLE   = cal_en_r;
    assign SOFT_RESET_N = srst_n_r;

    // Checks; each is off while the pin reset is low, and the soft reset
    // cycle is left out where it would clear the register being watched
    chk_addr_locked: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && !unlock_ok && !srst_r)
        |=> $stable(addr_r))
        else $error("address changed without a valid unlock key");
    chk_key_always: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_ALWAYS &&
         REQ.wdata[15:8] == `ARC_WRITE_KEY && !srst_r)
        |=> addr_r == $past(REQ.wdata[7:1]))
        else $error("unconditional key did not take the address");
    chk_key_int: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_INT && !INT_PIN &&
         !srst_r) |=> $stable(addr_r))
        else $error("address changed with interrupt pin low");
    chk_key_int_open: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_INT && INT_PIN &&
         REQ.wdata[15:8] == `ARC_WRITE_KEY && !srst_r)
        |=> addr_r == $past(REQ.wdata[7:1]))
        else $error("interrupt pin high did not take the address");
    chk_key_aux: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_AUX && !AUX_OUTPUT_PIN &&
         !srst_r) |=> $stable(addr_r))
        else $error("address changed with aux pin low");
    chk_key_aux_open: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_AUX && AUX_OUTPUT_PIN &&
         REQ.wdata[15:8] == `ARC_WRITE_KEY && !srst_r)
        |=> addr_r == $past(REQ.wdata[7:1]))
        else $error("aux pin high did not take the address");
    chk_key_both: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_BOTH &&
         !(INT_PIN && AUX_OUTPUT_PIN) && !srst_r)
        |=> $stable(addr_r))
        else $error("address changed without both pins high");
    chk_key_both_open: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr && hit_addr && key_r == `ARC_KEY_BOTH && INT_PIN &&
         AUX_OUTPUT_PIN && REQ.wdata[15:8] == `ARC_WRITE_KEY && !srst_r)
        |=> addr_r == $past(REQ.wdata[7:1]))
        else $error("both pins high did not take the address");
    chk_srst_pulse: assert property (
        @(posedge CLK) disable iff (!RSTN)
        srst_we && !srst_r |=> srst_r ##1 !srst_r)
        else $error("soft reset bit did not clear itself");
    chk_srst_clears: assert property (
        @(posedge CLK) disable iff (!RSTN)
        srst_r |=> key_r == `ARC_KEY_RST && addr_r == `ARC_ADDR_RST &&
        mode_r == arc_pkg::ARC_MODE_STANDBY)
        else $error("soft reset did not clear the registers");
    chk_srst_noack: assert property (
        @(posedge CLK) disable iff (!RSTN)
        srst_we && !srst_r |=> !ack_r)
        else $error("soft reset write was acknowledged");
    chk_ack_answer: assert property (
        @(posedge CLK) disable iff (!RSTN)
        (REQ.wr || REQ.rd) && !srst_we && !srst_r |=> ack_r)
        else $error("access was not acknowledged");
    chk_ack_idle: assert property (
        @(posedge CLK) disable iff (!RSTN)
        !(REQ.wr || REQ.rd) |=> !ack_r)
        else $error("acknowledge without an access");
    chk_mode_legal: assert property (
        @(posedge CLK) disable iff (!RSTN)
        mode_r != 2'h3)
        else $error("mode register holds an illegal code");
    chk_cal_idle: assert property (
        @(posedge CLK) disable iff (!RSTN)
        !cal_en_r && !srst_r |=> $stable(cal_count))
        else $error("calibration count moved while disabled");
    // A reset in the cycle before also moves the count, hence the guard
    chk_cal_latch: assert property (
        @(posedge CLK) disable iff (!RSTN)
        $past(rst_all_n) && $changed(cal_count) |-> cal_done)
        else $error("calibration count moved outside a window end");
endmodule

/* arc_defines.svh */
/*
 * Register offsets, field positions, reset values and keys of the
 * address / calibration / reset control block.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef ARC_DEFINES_SVH
`define ARC_DEFINES_SVH

`define ARC_OFS_ADDR      8'h09
`define ARC_OFS_CAL       8'h0A
`define ARC_OFS_KEY       8'h0D
`define ARC_OFS_SRST      8'h0F
`define ARC_OFS_MODE      8'h10
`define ARC_OFS_CALCTL    8'h50

`define ARC_WRITE_KEY     8'hAD
`define ARC_KEY_ALWAYS    16'h04AD
`define ARC_KEY_INT       16'h44AD
`define ARC_KEY_AUX       16'h84AD
`define ARC_KEY_BOTH      16'hC4AD

`define ARC_ADDR_RST      7'h64
`define ARC_KEY_RST       16'h0000
`define ARC_CAL_RST       12'h000
`define ARC_CAL_EN_BIT    5
`define ARC_CAL_SLOW_EDGES 2'h2

`endif

/* arc_pkg.sv */
/*
 * Types of the address / calibration / reset control block.
 * Assumes no surroundings beyond the defines header.
 */
package arc_pkg;
    typedef enum logic [1:0] {
        ARC_MODE_STANDBY = 2'h0,
        ARC_MODE_PROGRAM = 2'h1,
        ARC_MODE_NORMAL  = 2'h2
    } arc_mode_type;

    // One register access as presented by the serial front end
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } arc_req_type;
endpackage

/* arc_cal_counter.sv */
/*
 * Counts fast clock cycles across two slow clock periods.
 * Assumes the slow clock arrives as a level synchronous to CLK.
 */
`include "arc_defines.svh"

module arc_cal_counter (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        enable,
    input  wire logic        slow_clk,
    output logic [11:0]      count,
    output logic             done
);
    logic        slow_d_r;
    logic [1:0]  edges_r;
    logic [11:0] cnt_r;
    logic [11:0] count_r;
    logic        done_r;
    wire         rise = slow_clk & ~slow_d_r;

    // Slow clock history runs even while disabled and resets high, so a
    // slow clock that is already high at enable is not taken for an edge
    always_ff @(posedge clk) begin
        if (!rstn)
            slow_d_r <= 1'b1;
        else
            slow_d_r <= slow_clk;
    end

    // Rising edges frame the window; the count is latched two periods on
    always_ff @(posedge clk) begin
        if (!rstn || !enable) begin
            edges_r  <= 2'h0;
            cnt_r    <= 12'h000;
            done_r   <= 1'b0;
        end else begin
            done_r   <= 1'b0;
            if (rise && edges_r == 2'h0) begin
                edges_r <= 2'h1;
                cnt_r   <= 12'h000;
            end else if (edges_r != 2'h0) begin
                if (rise && edges_r == `ARC_CAL_SLOW_EDGES) begin
                    edges_r <= 2'h1;    // Restart for a fresh measurement
                    cnt_r   <= 12'h000;
                    done_r  <= 1'b1;
                end else begin
                    if (rise)
                        edges_r <= edges_r + 2'h1;
                    cnt_r <= cnt_r + 12'h001;
                end
            end
        end
    end

    // Result kept across disable so software can still read it
    always_ff @(posedge clk) begin
        if (!rstn)
            count_r <= `ARC_CAL_RST;
        else if (enable && rise && edges_r == `ARC_CAL_SLOW_EDGES)
            count_r <= cnt_r + 12'h001;
    end

    assign count = count_r;
    assign done  = done_r;
endmodule

/* arc_host_model.sv */
/*
 * Host side model: turns bench commands into one-cycle register accesses
 * and watches that each access is answered exactly as expected.
 * Assumes the bench raises go for one cycle per access.
 */
`include "arc_defines.svh"

module arc_host_model (
    input  wire logic            clk,
    input  wire logic            go,
    input  wire logic            wr,
    input  wire logic [7:0]      addr,
    input  wire logic [15:0]     wdata,
    input  wire logic            ack,
    output arc_pkg::arc_req_type req,
    output logic                 fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pend_r;
    logic srst_w;
    assign srst_w = go && wr && addr == `ARC_OFS_SRST && wdata[0];
    // key byte travels with the address in one word
    assign req = '{go && wr, go && !wr, addr, wdata};
    // A missing or spurious answer is a fault, so silence is not mistaken
    always_ff @(posedge clk) begin
        pend_r <= go && !srst_w;
        fault <= pend_r !== ack;
    end
endmodule

/* testbench.sv */
/*
 * Self-checking bench for the control register bank.
 * Assumes the host model and the design files are compiled first.
 */
`include "arc_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLOW_HALF = 20;
    logic        clk, rstn, go, wr, int_pin, aux_pin, slow_clk;
    logic        ack, fault, cal_en, srst_n;
    logic [7:0]  addr;
    logic [15:0] wdata, rdata;
    logic [6:0]  taddr, exp_a;
    logic [31:0] rnd;
    logic [16:0] e;
    logic [16:0] expq[$];
    int          errors, tests_run, cyc, slow_cnt;
    arc_pkg::arc_req_type  req;
    arc_pkg::arc_mode_type mode;
    logic [15:0] keys[5] = '{`ARC_KEY_ALWAYS, `ARC_KEY_INT, `ARC_KEY_AUX,
                             `ARC_KEY_BOTH, 16'h1234};

    arc_host_model u_host (.clk(clk), .go(go), .wr(wr), .addr(addr),
        .wdata(wdata), .ack(ack), .req(req), .fault(fault));
    arc_ctrl u_dut (.CLK(clk), .RSTN(rstn), .REQ(req), .INT_PIN(int_pin),
        .AUX_OUTPUT_PIN(aux_pin), .SLOW_CLK(slow_clk), .RDATA(rdata),
        .ACK(ack), .TARGET_ADDR(taddr), .MODE(mode), .CAL_ENABLE(cal_en),
        .SOFT_RESET_N(srst_n));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask

    // One access; the expected answer is noted before it is taken
    task automatic acc(input logic w, input logic [7:0] a,
                       input logic [15:0] d, input logic [15:0] x);
        @(posedge clk);
        go <= 1'b1;
        wr <= w;
        addr <= a;
        wdata <= d;
        if (!(w && a == `ARC_OFS_SRST && d[0])) expq.push_back({w, x});
        @(posedge clk);
        go <= 1'b0;
    endtask

    task automatic final_report;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Slow clock, cycle ceiling; the slow clock is scaled to keep runs short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        slow_cnt <= (slow_cnt == SLOW_HALF - 1) ? 0 : slow_cnt + 1;
        if (slow_cnt == SLOW_HALF - 1) slow_clk <= ~slow_clk;
        if (cyc == 20000) begin
            errors++;
            final_report();
        end
    end

    // Answers are matched in order against the noted expectations
    always @(negedge clk) begin
        if (rstn && fault === 1'b1)
            chk(16'h1, 16'h0, "answer pattern");
        if (rstn && ack === 1'b1) begin
            if (expq.size() == 0)
                chk(16'h1, 16'h0, "answer without access");
            else begin
                e = expq.pop_front();
                if (!e[16]) chk(rdata, e[15:0], "read data");
            end
        end
    end

    initial begin
        {rstn, go, wr, int_pin, aux_pin, slow_clk} = '0;
        addr = '0;
        wdata = '0;
        cyc = 0;
        slow_cnt = 0;
        rnd = 32'h70DFEF3B;
        exp_a = `ARC_ADDR_RST;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        acc(0, `ARC_OFS_KEY, 16'h0000, `ARC_KEY_RST);
        acc(0, `ARC_OFS_CAL, 16'h0000, 16'h0000);
        acc(0, 8'h33, 16'h0000, 16'h0000); // unmapped place
        for (int k = 0; k < 5; k++) begin
            for (int p = 0; p < 4; p++) begin
                @(posedge clk);
                int_pin <= p[0];
                aux_pin <= p[1];
                acc(1, `ARC_OFS_KEY, keys[k], 16'h0000);
                rnd = lfsr(rnd);
                acc(1, `ARC_OFS_ADDR, {8'h00, rnd[6:0], 1'b0}, 16'h0000);
                @(negedge clk);
                chk(16'(taddr), 16'(exp_a), "address no key");
                acc(1, `ARC_OFS_ADDR, {`ARC_WRITE_KEY, rnd[6:0], 1'b0},
                    16'h0000);
                if (k == 0 || (k == 1 && p[0]) || (k == 2 && p[1]) ||
                    (k == 3 && p == 3)) exp_a = rnd[6:0];
                @(negedge clk);
                chk(16'(taddr), 16'(exp_a), "keyed address");
            end
        end
        acc(0, `ARC_OFS_ADDR, 16'h0000, {8'h00, exp_a, 1'b0});
        for (int m = 0; m < 4; m++) begin
            acc(1, `ARC_OFS_MODE, 16'(m), 16'h0000);
            @(negedge clk);
            chk(16'(mode), m < 3 ? 16'(m) : 16'h0002, "mode");
        end
        acc(0, `ARC_OFS_MODE, 16'h0000, 16'h0002);
        acc(1, `ARC_OFS_CALCTL, 16'h0020, 16'h0000);
        @(negedge clk);
        chk(16'(cal_en), 16'h0001, "calibration enable");
        acc(0, `ARC_OFS_CALCTL, 16'h0000, 16'h0020);
        repeat (250) @(posedge clk);
        acc(0, `ARC_OFS_CAL, 16'h0000, 16'(4 * SLOW_HALF));
        acc(1, `ARC_OFS_SRST, 16'h0001, 16'h0000);
        @(negedge clk);
        chk(16'(srst_n), 16'h0000, "reset pulse");
        @(negedge clk);
        chk(16'(srst_n), 16'h0001, "reset released");
        chk(16'(taddr), 16'(`ARC_ADDR_RST), "address reset");
        chk(16'(mode), 16'h0000, "mode after reset");
        chk(16'(cal_en), 16'h0000, "enable after reset");
        repeat (2) @(posedge clk);
        acc(0, `ARC_OFS_SRST, 16'h0000, 16'h0000);
        acc(0, `ARC_OFS_KEY, 16'h0000, 16'h0000);
        repeat (3) @(posedge clk);
        chk(16'(expq.size()), 16'h0000, "answers outstanding");
        final_report();
    end
endmodule
